//--- common/ifp_pkg.sv
// Types shared by the interrupt flag and priority block
package ifp_pkg;
	// Number of interrupt lines
	localparam int unsigned NUM_LINES = 12;

	// Hardware request strobes from the peripherals
	typedef struct packed {
		logic flash_write_done;
		logic trap_exec;
		logic clock_req;
		logic timer2_req;
		logic timer3_req;
		logic radio_req;
		logic converter_local_flag;
		logic converter_local_en;
		logic cipher_local_flag;
		logic cipher_local_en;
	} ifp_hw_req_t;

	// Lower-numbered line flags owned by the core peripherals
	typedef struct packed {
		logic serial1;
		logic serial0;
		logic timer1;
		logic ext_in1;
		logic timer0;
		logic ext_in0;
	} ifp_base_flags_t;

	// Interrupt level
	typedef enum logic [1:0] {
		IFP_LVL_LOW,
		IFP_LVL_HIGH,
		IFP_LVL_TOP
	} ifp_level_t;

	// Arbitration result towards the core
	typedef struct packed {
		logic valid;
		logic [3:0] line;
	} ifp_grant_t;
endpackage : ifp_pkg

//--- common/ifp_regs.svh
// Register offsets, bit positions and reset values of the interrupt flag and priority block
`ifndef IFP_REGS_SVH
`define IFP_REGS_SVH

// ****************************************
// Register indices and byte address width
// ****************************************
`define IFP_IDX_XFLAGS 8'h91
`define IFP_IDX_PRIO 8'hb8
`define IFP_IDX_XCTRL 8'hd8
`define IFP_IDX_XPRIO 8'hf8
`define IFP_IDX_ENABLE 8'ha8
`define IFP_IDX_XENABLE 8'he8
`define IFP_IDX_SERVICE 8'h01
`define IFP_IDX_PENDING 8'h02
`define IFP_IDX_PENDING_HI 8'h03
`define IFP_ADDR_W 10

// ****************************************
// Bit positions
// ****************************************
`define IFP_XCTRL_RATE2 7
`define IFP_XCTRL_FLASHDBG_IRQ_EN 5
`define IFP_XCTRL_FLASHDBG_IRQ_FLAG 4
`define IFP_XCTRL_CLKF 3
`define IFP_XFLAGS_T3 7
`define IFP_XFLAGS_CONV 6
`define IFP_XFLAGS_T2 5
`define IFP_XFLAGS_RF 4
`define IFP_IE_GLOBAL 7
`define IFP_SVC_ACK 0
`define IFP_SVC_RETI 1

// ****************************************
// Read masks: fixed ones and writable bits
// ****************************************
`define IFP_XCTRL_ONES 8'h40
`define IFP_XCTRL_WMASK 8'hb8
`define IFP_XFLAGS_ONES 8'h08
`define IFP_XFLAGS_WMASK 8'hf0
`define IFP_PRIO_ONES 8'h80
`define IFP_PRIO_WMASK 8'h7f
`define IFP_XREG_ONES 8'he0
`define IFP_XREG_WMASK 8'h1f
`define IFP_RST_BYTE 8'h00

`endif

//--- hdl/ifp_core.sv
// Interrupt flag, enable and priority logic with classic Wishbone register access
//
// Contract
// - Control bit 7 doubles serial port 1 rate
// - Flash/debug enable works without global enable
// - Flash write done or trap sets flash flag
// - Software writing one sets any control or extended flag
// - Clock request sets control bit 3 flag
// - Timer 3 request sets flag bit 7
// - Converter or cipher request sets flag bit 6
// - Local enable gates converter and cipher requests
// - Timer 2 request sets flag bit 5
// - Radio request sets flag bit 4
// - Level compared first, natural order breaks ties
// - Only flash/debug sits at top level
// - Other sources low or high by bit
// - Smallest natural number wins among equals
// - Preempt running routine only at higher level
// - Priority bits map serial, timer, external sources
// - Twelve lines in fixed natural order
// - Global enable masks all except flash/debug
// - Extended priority bits for five sources
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "ifp_regs.svh"

module ifp_core #(
	parameter int unsigned LINES = ifp_pkg::NUM_LINES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`IFP_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Peripheral requests
	input wire ifp_pkg::ifp_hw_req_t hw_req,
	input wire ifp_pkg::ifp_base_flags_t base_flags,
	// Core side
	output ifp_pkg::ifp_grant_t grant,
	output logic serial1_rate_double
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] extended_irq_control;
	logic [7:0] extended_irq_flags;
	logic [7:0] irq_priority_basic;
	logic [7:0] irq_priority_extended;
	logic [7:0] irq_enable;
	logic [7:0] irq_enable_extended;
	// Levels of routines in progress, one bit per level
	logic [2:0] active_levels;
	logic [LINES-1:0] line_flag;
	logic [LINES-1:0] line_en;
	logic [LINES-1:0] line_hi;
	logic [LINES-1:0] pending;
	logic [7:0] next_rdata;
	logic wr_hit;
	logic svc_ack;
	logic svc_reti;
	logic [3:0] win_line;
	logic win_valid;
	ifp_pkg::ifp_level_t win_lvl;
	ifp_pkg::ifp_level_t run_lvl;
	logic conv_req;

	// Word index decode from byte address
	function automatic logic is_reg(input logic [`IFP_ADDR_W-1:0] adr, input logic [7:0] idx);
		is_reg = (adr[`IFP_ADDR_W-1:2] == idx) && (adr[1:0] == 2'h0);
	endfunction : is_reg

	// Level of a line from its priority bit
	function automatic ifp_pkg::ifp_level_t lvl_of(input logic [3:0] ln, input logic hi);
		if (ln == 4'h0) begin
			lvl_of = ifp_pkg::IFP_LVL_TOP;
		end else if (hi) begin
			lvl_of = ifp_pkg::IFP_LVL_HIGH;
		end else begin
			lvl_of = ifp_pkg::IFP_LVL_LOW;
		end
	endfunction : lvl_of

	// Byte-lane write strobe: only lane 0 carries the register
	assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	assign svc_ack = wr_hit && is_reg(wb_adr_i, `IFP_IDX_SERVICE) && wb_dat_i[`IFP_SVC_ACK];
	assign svc_reti = wr_hit && is_reg(wb_adr_i, `IFP_IDX_SERVICE) && wb_dat_i[`IFP_SVC_RETI];

	// Converter and cipher share one flag, each behind its local enable
	assign conv_req = (hw_req.converter_local_flag && hw_req.converter_local_en)
		|| (hw_req.cipher_local_flag && hw_req.cipher_local_en);

	// ****************************************
	// Control register
	// ****************************************
	// Hardware sets win over software clears
	always_ff @(posedge clk) begin
		if (srst) begin
			extended_irq_control <= `IFP_RST_BYTE;
		end else begin
			if (wr_hit && is_reg(wb_adr_i, `IFP_IDX_XCTRL)) begin
				extended_irq_control <= wb_dat_i[7:0] & `IFP_XCTRL_WMASK;
			end
			if (hw_req.flash_write_done || hw_req.trap_exec) begin
				extended_irq_control[`IFP_XCTRL_FLASHDBG_IRQ_FLAG] <= 1'b1;
			end
			if (hw_req.clock_req) begin
				extended_irq_control[`IFP_XCTRL_CLKF] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Extended flag register
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			extended_irq_flags <= `IFP_RST_BYTE;
		end else begin
			if (wr_hit && is_reg(wb_adr_i, `IFP_IDX_XFLAGS)) begin
				extended_irq_flags <= wb_dat_i[7:0] & `IFP_XFLAGS_WMASK;
			end
			if (hw_req.timer3_req) begin
				extended_irq_flags[`IFP_XFLAGS_T3] <= 1'b1;
			end
			if (conv_req) begin
				extended_irq_flags[`IFP_XFLAGS_CONV] <= 1'b1;
			end
			if (hw_req.timer2_req) begin
				extended_irq_flags[`IFP_XFLAGS_T2] <= 1'b1;
			end
			if (hw_req.radio_req) begin
				extended_irq_flags[`IFP_XFLAGS_RF] <= 1'b1;
			end
		end
	end

	// ****************************************
	// Priority and enable registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_priority_basic <= `IFP_RST_BYTE;
			irq_priority_extended <= `IFP_RST_BYTE;
			irq_enable <= `IFP_RST_BYTE;
			irq_enable_extended <= `IFP_RST_BYTE;
		end else begin
			if (wr_hit && is_reg(wb_adr_i, `IFP_IDX_PRIO)) begin
				irq_priority_basic <= wb_dat_i[7:0] & `IFP_PRIO_WMASK;
			end
			if (wr_hit && is_reg(wb_adr_i, `IFP_IDX_XPRIO)) begin
				irq_priority_extended <= wb_dat_i[7:0] & `IFP_XREG_WMASK;
			end
			if (wr_hit && is_reg(wb_adr_i, `IFP_IDX_ENABLE)) begin
				irq_enable <= wb_dat_i[7:0];
			end
			if (wr_hit && is_reg(wb_adr_i, `IFP_IDX_XENABLE)) begin
				irq_enable_extended <= wb_dat_i[7:0] & `IFP_XREG_WMASK;
			end
		end
	end

	// ****************************************
	// Line mapping in natural order
	// ****************************************
	// Line 0 flash/debug up to line 11 real-time clock
	always_comb begin
		line_flag = {extended_irq_control[`IFP_XCTRL_CLKF], extended_irq_flags[7:4],
			base_flags.serial1, base_flags.serial0, base_flags.timer1, base_flags.ext_in1,
			base_flags.timer0, base_flags.ext_in0, extended_irq_control[`IFP_XCTRL_FLASHDBG_IRQ_FLAG]};
		line_en = {irq_enable_extended[4], irq_enable_extended[3], irq_enable_extended[2],
			irq_enable_extended[1], irq_enable_extended[0], irq_enable[6], irq_enable[4],
			irq_enable[3:0], extended_irq_control[`IFP_XCTRL_FLASHDBG_IRQ_EN]};
		line_hi = {irq_priority_extended[4], irq_priority_extended[3], irq_priority_extended[2],
			irq_priority_extended[1], irq_priority_extended[0], irq_priority_basic[6],
			irq_priority_basic[4], irq_priority_basic[3:0], 1'b0};
	end

	// Pending gating per line
	genvar gi;
	generate
		for (gi = 0; gi < LINES; gi++) begin : g_pend
			if (gi == 0) begin : g_fd
				assign pending[gi] = line_flag[gi] && line_en[gi];
			end else begin : g_oth
				assign pending[gi] = line_flag[gi] && line_en[gi]
					&& irq_enable[`IFP_IE_GLOBAL];
			end
		end
	endgenerate

	// ****************************************
	// Arbitration
	// ****************************************
	// Highest level first, lowest line number within a level
	always_comb begin
		win_valid = 1'b0;
		win_line = 4'h0;
		win_lvl = ifp_pkg::IFP_LVL_LOW;
		for (int i = LINES - 1; i >= 0; i--) begin
			if (pending[i] && (!win_valid
				|| lvl_of(4'(i), line_hi[i]) >= win_lvl)) begin
				win_valid = 1'b1;
				win_line = 4'(i);
				win_lvl = lvl_of(4'(i), line_hi[i]);
			end
		end
	end

	// Current running level, if any
	always_comb begin
		if (active_levels[2]) begin
			run_lvl = ifp_pkg::IFP_LVL_TOP;
		end else if (active_levels[1]) begin
			run_lvl = ifp_pkg::IFP_LVL_HIGH;
		end else begin
			run_lvl = ifp_pkg::IFP_LVL_LOW;
		end
	end

	// Request to core, preempting only at strictly higher level
	always_ff @(posedge clk) begin
		if (srst) begin
			grant <= '0;
		end else begin
			grant.valid <= win_valid && (active_levels == 3'h0 || win_lvl > run_lvl);
			grant.line <= win_line;
		end
	end

	// Service tracking: core acknowledges entry and return
	always_ff @(posedge clk) begin
		if (srst) begin
			active_levels <= 3'h0;
		end else if (svc_ack && grant.valid) begin
			active_levels[lvl_of(grant.line, line_hi[grant.line])] <= 1'b1;
		end else if (svc_reti) begin
			if (active_levels[2]) begin
				active_levels[2] <= 1'b0;
			end else if (active_levels[1]) begin
				active_levels[1] <= 1'b0;
			end else begin
				active_levels[0] <= 1'b0;
			end
		end
	end

	// Rate doubler output
	always_ff @(posedge clk) begin
		if (srst) begin
			serial1_rate_double <= 1'b0;
		end else begin
			serial1_rate_double <= extended_irq_control[`IFP_XCTRL_RATE2];
		end
	end

	// ****************************************
	// Read path and acknowledge
	// ****************************************
	always_comb begin
		next_rdata = 8'h00;
		if (is_reg(wb_adr_i, `IFP_IDX_XCTRL)) begin
			next_rdata = extended_irq_control | `IFP_XCTRL_ONES;
		end else if (is_reg(wb_adr_i, `IFP_IDX_XFLAGS)) begin
			next_rdata = extended_irq_flags | `IFP_XFLAGS_ONES;
		end else if (is_reg(wb_adr_i, `IFP_IDX_PRIO)) begin
			next_rdata = irq_priority_basic | `IFP_PRIO_ONES;
		end else if (is_reg(wb_adr_i, `IFP_IDX_XPRIO)) begin
			next_rdata = irq_priority_extended | `IFP_XREG_ONES;
		end else if (is_reg(wb_adr_i, `IFP_IDX_ENABLE)) begin
			next_rdata = irq_enable;
		end else if (is_reg(wb_adr_i, `IFP_IDX_XENABLE)) begin
			next_rdata = irq_enable_extended | `IFP_XREG_ONES;
		end else if (is_reg(wb_adr_i, `IFP_IDX_SERVICE)) begin
			next_rdata = {5'h00, active_levels};
		end else if (is_reg(wb_adr_i, `IFP_IDX_PENDING)) begin
			next_rdata = pending[7:0];
		end else if (is_reg(wb_adr_i, `IFP_IDX_PENDING_HI)) begin
			next_rdata = {4'h0, pending[11:8]};
		end
	end

	// One-cycle ack, unmapped reads return zero
	always_ff @(posedge clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= {24'h0, next_rdata};
		end
	end

endmodule : ifp_core

//--- verification/ifp_core_props.sv
// Checker of bus timing, read masks and reset of the flag block
`timescale 1ns/1ps
module ifp_core_props (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Core side
	input wire ifp_pkg::ifp_grant_t grant,
	input wire logic serial1_rate_double
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic rd;
	logic req;
	// Read answer and new request
	assign rd = wb_ack_o && !wb_we_i;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// ****************
	// Properties
	// ****************
	ack_once_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack is not one pulse a cycle after request");
	rate_copy_a: assert property (req && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h360
		|=> ##1 serial1_rate_double == $past(wb_dat_i[7], 2))
		else $error("rate double does not follow control bit 7");
	ctrl_fixed_a: assert property (rd && wb_adr_i == 10'h360
		|-> wb_dat_o[6] && wb_dat_o[2:0] == 3'h0) else $error("control fixed bits wrong");
	flag_fixed_a: assert property (rd && wb_adr_i == 10'h244 |-> wb_dat_o[3:0] == 4'h8)
		else $error("flag fixed bits wrong");
	prio_fixed_a: assert property (rd && wb_adr_i == 10'h2e0 |-> wb_dat_o[7])
		else $error("priority bit 7 not one");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	unmap_zero_a: assert property (rd && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0)
		else $error("misaligned read not zero");
	line_range_a: assert property (grant.valid |-> grant.line < 4'hc)
		else $error("granted line out of range");
	reset_quiet_a: assert property ($fell(srst) |-> !wb_ack_o && grant == 5'h0
		&& !serial1_rate_double) else $error("outputs not cleared by reset");
	cover property (rd);
	cover property (grant.valid && grant.line == 4'h0);
	cover property (serial1_rate_double);
endmodule : ifp_core_props

bind ifp_core ifp_core_props u_props (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .grant(grant),
	.serial1_rate_double(serial1_rate_double));

//--- verification/ifp_core_tb.sv
// Self-checking bench of the flag and priority block
`timescale 1ns/1ps
module ifp_core_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, serial1_rate_double;
	ifp_pkg::ifp_hw_req_t hw_req;
	ifp_pkg::ifp_base_flags_t base_flags;
	ifp_pkg::ifp_grant_t grant;
	logic [7:0] exp_q[$];
	logic [7:0] rv;
	int n_errors = 0, n_compared = 0, seed = 29;
	logic [9:0] hw_v[10] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010,
		10'h00c, 10'h003, 10'h008, 10'h002};
	logic [7:0] hw_a[10] = '{8'hd8, 8'hd8, 8'hd8, 8'h91, 8'h91, 8'h91, 8'h91, 8'h91,
		8'h91, 8'h91};
	logic [7:0] hw_e[10] = '{8'h50, 8'h50, 8'h48, 8'h28, 8'h88, 8'h18, 8'h48, 8'h48,
		8'h08, 8'h08};
	// 50 MHz clock
	always #10 clk = ~clk;
	ifp_core u_dut (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hw_req(hw_req), .base_flags(base_flags),
		.grant(grant), .serial1_rate_double(serial1_rate_double));
	ifp_periph_model u_per (.clk(clk), .hw_req(hw_req), .base_flags(base_flags));
	// ****************
	// Checks and bus cycles
	// ****************
	task automatic cmp_rd(input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR read data expected %h seen %h", e, s);
		end
	endtask : cmp_rd
	task automatic cmp_gnt(input logic [4:0] e);
		logic [4:0] s;
		s = e[4] ? grant : grant & 5'h10;
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR grant expected %h seen %h", e, s);
		end
	endtask : cmp_gnt
	task automatic cmp_rate(input logic e);
		n_compared++;
		if (serial1_rate_double !== e) begin
			n_errors++;
			$display("ERROR rate double expected %b seen %b", e, serial1_rate_double);
		end
	endtask : cmp_rate
	// Classic single cycle, held until ack is sampled
	task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] s);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h0, d};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, {i, 2'h0}, d, 4'h1);
	endtask : wr
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, {i, 2'h0}, 8'h0, 4'h1);
	endtask : rd
	task automatic chk(input logic [4:0] e);
		repeat (2) @(posedge clk);
		cmp_gnt(e);
	endtask : chk
	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	// Read answers against the oldest note
	always @(posedge clk) begin
		if (wb_ack_o === 1'b1 && !wb_we_i) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("ERROR read data expected none seen %h", wb_dat_o[7:0]);
			end else begin
				cmp_rd(exp_q.pop_front(), wb_dat_o[7:0]);
			end
		end
	end
	// Hang guard
	initial begin
		#200us;
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(8'hd8, 8'h40);
		rd(8'h91, 8'h08);
		rd(8'hb8, 8'h80);
		rd(8'hf8, 8'he0);
		rd(8'ha8, 8'h00);
		rd(8'hff, 8'h00);
		// Misaligned read answers zero
		exp_q.push_back(8'h00);
		bus(1'b0, 10'h362, 8'h00, 4'h1);
		$display("test reset values done");
		bus(1'b1, 10'h360, 8'h80, 4'h0);
		rd(8'hd8, 8'h40);
		wr(8'hd8, 8'h98);
		cmp_rate(1'b1);
		rd(8'hd8, 8'hd8);
		wr(8'h91, 8'hf0);
		rd(8'h91, 8'hf8);
		wr(8'hd8, 8'h00);
		cmp_rate(1'b0);
		wr(8'h91, 8'h00);
		rd(8'hd8, 8'h40);
		rd(8'h91, 8'h08);
		for (int i = 0; i < 4; i++) begin
			rv = 8'($random(seed));
			wr(8'hb8, rv);
			rd(8'hb8, rv | 8'h80);
			wr(8'hf8, rv);
			rd(8'hf8, {3'h7, rv[4:0]});
		end
		$display("test software access done");
		for (int i = 0; i < 10; i++) begin
			u_per.pulse(hw_v[i]);
			rd(hw_a[i], hw_e[i]);
			wr(hw_a[i], 8'h00);
		end
		$display("test hardware events done");
		wr(8'hb8, 8'h00);
		wr(8'hf8, 8'h00);
		wr(8'hd8, 8'h30);
		chk(5'h10);
		wr(8'ha8, 8'h90);
		wr(8'he8, 8'h03);
		wr(8'h91, 8'h30);
		u_per.set_base(6'h10);
		chk(5'h10);
		wr(8'hd8, 8'h20);
		chk(5'h15);
		wr(8'hf8, 8'h02);
		chk(5'h18);
		wr(8'h01, 8'h01);
		wr(8'hb8, 8'h10);
		chk(5'h00);
		rd(8'h01, 8'h02);
		rd(8'h91, 8'h38);
		wr(8'hd8, 8'h30);
		chk(5'h10);
		wr(8'h01, 8'h02);
		wr(8'hd8, 8'h20);
		chk(5'h15);
		wr(8'ha8, 8'h00);
		chk(5'h00);
		$display("test arbitration done");
		finish_test();
	end
endmodule : ifp_core_tb

//--- verification/ifp_periph_model.sv
// Peripheral request sources beside the flag block
`timescale 1ns/1ps
module ifp_periph_model (
	// Clock
	input wire logic clk,
	// Requests towards the block
	output ifp_pkg::ifp_hw_req_t hw_req,
	output ifp_pkg::ifp_base_flags_t base_flags
);
	// Idle levels at time zero
	initial begin
		hw_req = '0;
		base_flags = '0;
	end
	// One-cycle request from a peripheral
	task automatic pulse(input ifp_pkg::ifp_hw_req_t v);
		@(posedge clk);
		hw_req <= v;
		@(posedge clk);
		hw_req <= '0;
	endtask : pulse
	// Level flags of the core peripherals
	task automatic set_base(input ifp_pkg::ifp_base_flags_t v);
		@(posedge clk);
		base_flags <= v;
	endtask : set_base
endmodule : ifp_periph_model
